/* hw/lcd_pixel_clock_pkg.sv */
// LCD clock source package: register map, fields, reset values, types.
// Assumes one system clock (aclk) and an AXI4-Lite register bus.
package lcd_pixel_clock_pkg;
  // Clock rate of aclk
  localparam int unsigned CLK_HZ = 25_000_000;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_LCD_CONTROL = 10'h047;
  localparam logic [9:0] IDX_LCD_CLOCK   = 10'h048;
  localparam logic [9:0] IDX_FRA         = 10'h049;
  localparam logic [9:0] IDX_LINE_LEN    = 10'h04a;
  localparam logic [9:0] IDX_LINE_CNT    = 10'h04b;
  localparam logic [9:0] IDX_PAN         = 10'h04c;
  localparam logic [9:0] IDX_PUMP        = 10'h04d;
  localparam logic [9:0] IDX_SYS         = 10'h04e;
  localparam logic [9:0] IDX_IRQ_EN      = 10'h04f;
  localparam logic [9:0] IDX_IRQ_REQ     = 10'h050;

  // Reset values
  localparam logic [7:0] RST_LCD_CONTROL = 8'h80;
  localparam logic [7:0] RST_LCD_CLOCK   = 8'h00;
  localparam logic [7:0] RST_ZERO        = 8'h00;
  localparam logic [7:0] RST_PUMP        = 8'h02;
  localparam logic [7:0] PUMP_32K        = 8'h00;

  // Field positions
  localparam int BIT_OFF        = 7;
  localparam int BIT_BLINK      = 6;
  localparam int BIT_REV        = 5;
  localparam int BIT_CAS        = 4;
  localparam int GL_LSB         = 2;
  localparam int LCD_BUS_WIDTH_LSB       = 4;
  localparam int SYS_SEL_BIT    = 7;
  localparam int IRQ_FRAME_BIT  = 7;
  localparam int IRQ_SWITCH_BIT = 0;

  // Extra prescale of fast black/white mode
  localparam logic [7:0] FAST_DIV = 8'h08;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    GL_BW   = 2'h0,
    GL_G4   = 2'h1,
    GL_G16  = 2'h2,
    GL_FAST = 2'h3
  } lcd_pixel_clock_gl_e;

  typedef enum logic [3:0] {
    SRC_RC   = 4'h1,
    SRC_GO32 = 4'h2,
    SRC_K32  = 4'h4,
    SRC_GORC = 4'h8
  } lcd_pixel_clock_src_e;

  typedef struct packed {
    logic       display_off_bit;
    logic       blink_bit;
    logic       reverse_video_bit;
    logic       cascade_bit;
    lcd_pixel_clock_gl_e  gray_level_sel;
    logic [1:0] lcd_bus_width;
    logic [7:0] panning_offset;
    logic [7:0] pump_clock_sel;
    logic       on_32k;
  } lcd_pixel_clock_out_s;
endpackage

/* hw/lcd_pixel_clock_div.sv */
// LCD pixel clock divider: one tick per LCD clock period.
// Assumes slow_tick is a synchronised one-cycle edge of the 32 kHz source.
`timescale 1ns/1ns
module lcd_pixel_clock_div
  import lcd_pixel_clock_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       use_slow,
  input  wire logic       slow_tick,
  input  wire logic       fast,
  input  wire logic [3:0] divider,
  output logic            tick_ff
);
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic       nxt_tick;
  logic [7:0] period;

  // Period: 1 at zero, else twice the field, times eight in fast mode
  always_comb
  begin
    period = (divider == 4'h0) ? 8'h01 : {3'h0, divider, 1'b0};
    if (fast)
      period = 8'(period * FAST_DIV);
    nxt_cnt  = cnt_ff;
    nxt_tick = 1'b0;
    if (use_slow)
    begin
      nxt_cnt  = 8'h00;
      nxt_tick = slow_tick;
    end
    else if (cnt_ff >= 8'(period - 8'h01))
    begin
      nxt_cnt  = 8'h00;
      nxt_tick = 1'b1;
    end
    else
      nxt_cnt = 8'(cnt_ff + 8'h01);
  end

  // Register state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_ff  <= 8'h00;
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end
endmodule

/* hw/lcd_pixel_clock_frame.sv */
// Frame timer: counts LCD clock ticks and pulses at each frame end.
// Assumes tick is a one-cycle pulse from the divider.
`timescale 1ns/1ns
module lcd_pixel_clock_frame
  import lcd_pixel_clock_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       tick,
  input  wire logic [7:0] line_length_max,
  input  wire logic [7:0] frame_rate_adjust,
  input  wire logic [7:0] line_count_max,
  output logic            frame_ff
);
  logic [17:0] cnt_ff;
  logic [17:0] nxt_cnt;
  logic        nxt_frame;
  logic [17:0] flen;

  // Frame length in ticks: (len + adjust + 1) * (count * 2)
  always_comb
  begin
    flen = 18'((10'(line_length_max) + 10'(frame_rate_adjust) + 10'h001)
           * {line_count_max, 1'b0});
    nxt_cnt   = cnt_ff;
    nxt_frame = 1'b0;
    if (tick)
    begin
      if (18'(cnt_ff + 18'h00001) >= flen)
      begin
        nxt_cnt   = 18'h00000;
        nxt_frame = 1'b1;
      end
      else
        nxt_cnt = 18'(cnt_ff + 18'h00001);
    end
  end

  // Register state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_ff   <= 18'h00000;
      frame_ff <= 1'b0;
    end
    else
    begin
      cnt_ff   <= nxt_cnt;
      frame_ff <= nxt_frame;
    end
  end
endmodule

/* hw/lcd_pixel_clock_top.sv */
// LCD clock source, divider, frame timer and system clock switch.
// Assumes an AXI4-Lite master and a 32 kHz crystal level on a pin.
`timescale 1ns/1ns
module lcd_pixel_clock_top
  import lcd_pixel_clock_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        slow_crystal_osc,
  output logic             lcd_pixel_clock,
  output logic             lcd_frame,
  output logic             irq,
  output lcd_pixel_clock_out_s       lcd_out
);
  // Address match on an aligned word
  function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  logic [7:0]  ctl_ff, lck_ff, fra_ff, llen_ff, lcnt_ff, pan_ff, pump_ff;
  logic [7:0]  ien_ff, ireq_ff;
  logic [7:0]  nxt_ctl, nxt_lck, nxt_fra, nxt_llen, nxt_lcnt, nxt_pan, nxt_pump;
  logic [7:0]  nxt_ien, nxt_ireq;
  logic        sel_ff, nxt_sel;
  lcd_pixel_clock_src_e  src_ff, nxt_src;
  logic        awready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic        nxt_awready, nxt_bvalid, nxt_arready, nxt_rvalid;
  logic [1:0]  bresp_ff, rresp_ff, nxt_bresp, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        s1_ff, s2_ff, s3_ff, slow_lvl_ff, nxt_slow_lvl;
  logic        slow_edge, on_32k, wr_go, rd_go, wr_map, rd_map;
  logic        div_tick, frame_ev, done_ev;
  logic        irq_ff, nxt_irq, pix_ff, frm_ff;
  lcd_pixel_clock_out_s  out_ff, nxt_out;
  lcd_pixel_clock_gl_e   gl_eff;
  logic [7:0]  set_req, clr_req, rd_val;

  assign awready         = awready_ff;
  assign wready          = awready_ff;
  assign bvalid          = bvalid_ff;
  assign bresp           = bresp_ff;
  assign arready         = arready_ff;
  assign rvalid          = rvalid_ff;
  assign rdata           = rdata_ff;
  assign rresp           = rresp_ff;
  assign irq             = irq_ff;
  assign lcd_pixel_clock = pix_ff;
  assign lcd_frame       = frm_ff;
  assign lcd_out         = out_ff;

  // Pin synchroniser; a change counts once second and third agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_ff       <= 1'b0;
      s2_ff       <= 1'b0;
      s3_ff       <= 1'b0;
      slow_lvl_ff <= 1'b0;
    end
    else
    begin
      s1_ff       <= slow_crystal_osc;
      s2_ff       <= s1_ff;
      s3_ff       <= s2_ff;
      slow_lvl_ff <= nxt_slow_lvl;
    end
  end
  assign nxt_slow_lvl = (s2_ff == s3_ff) ? s3_ff : slow_lvl_ff;
  assign slow_edge    = (s2_ff == s3_ff) && s3_ff && !slow_lvl_ff;

  // Source state: the LCD runs from the slow clock once switched
  assign on_32k = (src_ff == SRC_K32) || (src_ff == SRC_GORC);
  assign gl_eff = on_32k ? GL_FAST : lcd_pixel_clock_gl_e'(ctl_ff[GL_LSB +: 2]);

  // AXI handshakes: address and data are taken together
  assign wr_go  = awready_ff && awvalid && wvalid;
  assign rd_go  = arready_ff && arvalid;
  assign wr_map = hit(awaddr, IDX_LCD_CONTROL) || hit(awaddr, IDX_LCD_CLOCK) ||
                  hit(awaddr, IDX_FRA) || hit(awaddr, IDX_LINE_LEN) ||
                  hit(awaddr, IDX_LINE_CNT) || hit(awaddr, IDX_PAN) ||
                  hit(awaddr, IDX_PUMP) || hit(awaddr, IDX_SYS) ||
                  hit(awaddr, IDX_IRQ_EN) || hit(awaddr, IDX_IRQ_REQ);

  // Read mux; the clock register is write-only and reads zero
  always_comb
  begin
    rd_map = 1'b1;
    rd_val = 8'h00;
    if (hit(araddr, IDX_LCD_CONTROL))
      rd_val = ctl_ff;
    else if (hit(araddr, IDX_LCD_CLOCK))
      rd_val = 8'h00;
    else if (hit(araddr, IDX_FRA))
      rd_val = fra_ff;
    else if (hit(araddr, IDX_LINE_LEN))
      rd_val = llen_ff;
    else if (hit(araddr, IDX_LINE_CNT))
      rd_val = lcnt_ff;
    else if (hit(araddr, IDX_PAN))
      rd_val = pan_ff;
    else if (hit(araddr, IDX_PUMP))
      rd_val = pump_ff;
    else if (hit(araddr, IDX_SYS))
      rd_val = {on_32k, 7'h00};
    else if (hit(araddr, IDX_IRQ_EN))
      rd_val = ien_ff;
    else if (hit(araddr, IDX_IRQ_REQ))
      rd_val = ireq_ff;
    else
      rd_map = 1'b0;
  end

  // Bus channel next state
  always_comb
  begin
    nxt_awready = !awready_ff && !bvalid_ff && awvalid && wvalid;
    nxt_bvalid  = bvalid_ff && !bready;
    nxt_bresp   = bresp_ff;
    nxt_arready = !arready_ff && !rvalid_ff && arvalid;
    nxt_rvalid  = rvalid_ff && !rready;
    nxt_rresp   = rresp_ff;
    nxt_rdata   = rdata_ff;
    if (wr_go)
    begin
      nxt_bvalid = 1'b1;
      nxt_bresp  = wr_map ? RESP_OKAY : RESP_DECERR;
    end
    if (rd_go)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = rd_map ? RESP_OKAY : RESP_DECERR;
      nxt_rdata  = {24'h000000, rd_val};
    end
  end

  // Source switch: on_32k changes only on a synchronised slow clock edge
  always_comb
  begin
    nxt_src = src_ff;
    done_ev = 1'b0;
    case (src_ff)
      SRC_RC:   if (sel_ff) nxt_src = SRC_GO32;
      SRC_GO32:
      begin
        if (!sel_ff)
          nxt_src = SRC_RC;
        else if (slow_edge)
        begin
          nxt_src = SRC_K32;
          done_ev = 1'b1;
        end
      end
      SRC_K32:  if (!sel_ff) nxt_src = SRC_GORC;
      SRC_GORC:
      begin
        if (slow_edge)
        begin
          nxt_src = SRC_RC;
          done_ev = 1'b1;
        end
      end
      default:  nxt_src = SRC_RC;
    endcase
  end

  // Register file, pump override and sticky requests
  always_comb
  begin
    nxt_ctl  = ctl_ff;
    nxt_lck  = lck_ff;
    nxt_fra  = fra_ff;
    nxt_llen = llen_ff;
    nxt_lcnt = lcnt_ff;
    nxt_pan  = pan_ff;
    nxt_pump = pump_ff;
    nxt_sel  = sel_ff;
    nxt_ien  = ien_ff;
    clr_req  = 8'h00;
    if (wr_go && wstrb[0])
    begin
      if (hit(awaddr, IDX_LCD_CONTROL)) nxt_ctl = wdata[7:0];
      if (hit(awaddr, IDX_LCD_CLOCK)) nxt_lck = {2'b00, wdata[5:0]};
      if (hit(awaddr, IDX_FRA) && !on_32k) nxt_fra = wdata[7:0];
      if (hit(awaddr, IDX_LINE_LEN)) nxt_llen = wdata[7:0];
      if (hit(awaddr, IDX_LINE_CNT)) nxt_lcnt = wdata[7:0];
      if (hit(awaddr, IDX_PAN)) nxt_pan = wdata[7:0];
      if (hit(awaddr, IDX_PUMP)) nxt_pump = wdata[7:0];
      if (hit(awaddr, IDX_SYS)) nxt_sel = wdata[SYS_SEL_BIT];
      if (hit(awaddr, IDX_IRQ_EN)) nxt_ien = wdata[7:0];
      if (hit(awaddr, IDX_IRQ_REQ)) clr_req = ~wdata[7:0];
    end
    // Entering the slow source drops the pump to 32 kHz
    if (src_ff == SRC_GO32 && nxt_src == SRC_K32)
      nxt_pump = PUMP_32K;
    set_req = 8'h00;
    set_req[IRQ_FRAME_BIT]  = frame_ev;
    set_req[IRQ_SWITCH_BIT] = done_ev;
    nxt_ireq = (ireq_ff & ~clr_req) | set_req;
    nxt_irq  = |(ireq_ff & ien_ff);
  end

  // Output image of the effective settings
  always_comb
  begin
    nxt_out.display_off_bit   = ctl_ff[BIT_OFF];
    nxt_out.blink_bit         = ctl_ff[BIT_BLINK];
    nxt_out.reverse_video_bit = ctl_ff[BIT_REV];
    nxt_out.cascade_bit       = ctl_ff[BIT_CAS];
    nxt_out.gray_level_sel    = gl_eff;
    nxt_out.lcd_bus_width     = lck_ff[LCD_BUS_WIDTH_LSB +: 2];
    nxt_out.panning_offset    = on_32k ? 8'h00 : pan_ff;
    nxt_out.pump_clock_sel    = pump_ff;
    nxt_out.on_32k            = on_32k;
  end

  // LCD clock from the system clock, or the slow edge once switched
  lcd_pixel_clock_div u_div (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .use_slow  (on_32k),
    .slow_tick (slow_edge),
    .fast      (gl_eff == GL_FAST),
    .divider   (lck_ff[3:0]),
    .tick_ff   (div_tick)
  );

  // Frame timer
  lcd_pixel_clock_frame u_frame (
    .aclk              (aclk),
    .aresetn           (aresetn),
    .tick              (div_tick),
    .line_length_max   (llen_ff),
    .frame_rate_adjust (fra_ff),
    .line_count_max    (lcnt_ff),
    .frame_ff          (frame_ev)
  );

  // Register all state except the pin synchroniser
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl_ff     <= RST_LCD_CONTROL;
      lck_ff     <= RST_LCD_CLOCK;
      fra_ff     <= RST_ZERO;
      llen_ff    <= RST_ZERO;
      lcnt_ff    <= RST_ZERO;
      pan_ff     <= RST_ZERO;
      pump_ff    <= RST_PUMP;
      sel_ff     <= 1'b0;
      ien_ff     <= RST_ZERO;
      ireq_ff    <= RST_ZERO;
      src_ff     <= SRC_RC;
      awready_ff <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= RESP_OKAY;
      rdata_ff   <= 32'h00000000;
      irq_ff     <= 1'b0;
      pix_ff     <= 1'b0;
      frm_ff     <= 1'b0;
      out_ff     <= '0;
    end
    else
    begin
      ctl_ff     <= nxt_ctl;
      lck_ff     <= nxt_lck;
      fra_ff     <= nxt_fra;
      llen_ff    <= nxt_llen;
      lcnt_ff    <= nxt_lcnt;
      pan_ff     <= nxt_pan;
      pump_ff    <= nxt_pump;
      sel_ff     <= nxt_sel;
      ien_ff     <= nxt_ien;
      ireq_ff    <= nxt_ireq;
      src_ff     <= nxt_src;
      awready_ff <= nxt_awready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rresp_ff   <= nxt_rresp;
      rdata_ff   <= nxt_rdata;
      irq_ff     <= nxt_irq;
      pix_ff     <= div_tick;
      frm_ff     <= frame_ev;
      out_ff     <= nxt_out;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_cfg2;
    !on_32k && lck_ff[3:0] == 4'h1 && gl_eff != GL_FAST;
  endsequence
  sequence s_cfg8;
    !on_32k && lck_ff[3:0] == 4'h0 && gl_eff == GL_FAST;
  endsequence

  property p_off_reset;
    $rose(aresetn) |-> ctl_ff[BIT_OFF];
  endproperty
  a_off_reset: assert property (p_off_reset) else $error("display not off after reset");

  property p_bw_32k;
    on_32k |=> out_ff.gray_level_sel == GL_FAST && out_ff.panning_offset == 8'h00;
  endproperty
  a_bw_32k: assert property (p_bw_32k) else $error("gray or panning active on 32k");

  property p_switch_edge;
    $changed(on_32k) |-> $past(slow_edge) && $past(done_ev);
  endproperty
  a_switch_edge: assert property (p_switch_edge) else $error("source changed off a slow edge");

  property p_fra_lock;
    on_32k && wr_go && hit(awaddr, IDX_FRA) |=> $stable(fra_ff);
  endproperty
  a_fra_lock: assert property (p_fra_lock) else $error("frame adjust changed on 32k");

  property p_pump;
    src_ff == SRC_GO32 && sel_ff && slow_edge |=> pump_ff == PUMP_32K ##0 on_32k;
  endproperty
  a_pump: assert property (p_pump) else $error("pump not dropped to 32k");

  property p_irq_keep;
    ireq_ff[IRQ_SWITCH_BIT] && wr_go && wstrb[0] && hit(awaddr, IDX_IRQ_REQ)
      && wdata[7:0] == 8'h7f |=> ireq_ff[IRQ_SWITCH_BIT] && (!ireq_ff[IRQ_FRAME_BIT] || $past(frame_ev));
  endproperty
  a_irq_keep: assert property (p_irq_keep) else $error("request clear hit other bits");

  property p_tick_32k;
    on_32k && slow_edge |=> div_tick ##1 pix_ff;
  endproperty
  a_tick_32k: assert property (p_tick_32k) else $error("32k tick missing");

  property p_div2;
    (div_tick and s_cfg2) ##1 s_cfg2 |=> div_tick && $past(!div_tick);
  endproperty
  a_div2: assert property (p_div2) else $error("divide by two wrong");

  property p_div8;
    (div_tick and s_cfg8) ##1 s_cfg8 [*7] |=> div_tick;
  endproperty
  a_div8: assert property (p_div8) else $error("fast divide by eight wrong");

  property p_frame_tick;
    frame_ev |-> $past(div_tick) ##1 frm_ff;
  endproperty
  a_frame_tick: assert property (p_frame_tick) else $error("frame off an LCD tick");
endmodule

/* test/lcd_pixel_clock_panel_model.sv */
// Far side model: free running 32 kHz crystal and a panel timing monitor.
// Assumes pixel and frame outputs are one-cycle pulses on aclk.
`timescale 1ns/1ns
module lcd_pixel_clock_panel_model
(
  input  wire logic aclk,
  input  wire logic lcd_pixel_clock,
  input  wire logic lcd_frame,
  output logic      slow_crystal_osc,
  output int        pix_period,
  output int        frm_period
);
  int pix_cnt = 0;
  int frm_cnt = 0;

  // Crystal runs free, half period 15260 ns, edges kept off the aclk edges
  initial
  begin
    slow_crystal_osc = 1'b0;
    #7;
    forever #15260 slow_crystal_osc = ~slow_crystal_osc;
  end

  // Cycles between successive pixel and frame pulses; report before restarting
  always @(posedge aclk)
  begin
    if (lcd_pixel_clock)
    begin
      pix_period <= pix_cnt;
      pix_cnt = 1;
    end
    else
      pix_cnt = pix_cnt + 1;
    if (lcd_frame)
    begin
      frm_period <= frm_cnt;
      frm_cnt = 1;
    end
    else
      frm_cnt = frm_cnt + 1;
  end
endmodule

/* test/lcd_pixel_clock_top_tb_top.sv */
// Bench: drives registers over AXI4-Lite and checks clocks, frames, irq, switch.
// Assumes the panel model supplies the crystal and measures pulse spacing.
`timescale 1ns/1ns
module lcd_pixel_clock_top_tb_top
  import lcd_pixel_clock_pkg::*;
;
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] awaddr  = 12'h0;
  logic        awvalid = 1'b0;
  logic [31:0] wdata   = 32'h0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic [11:0] araddr  = 12'h0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, slow_osc, pix, frm, irq;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, rd;
  lcd_pixel_clock_out_s  lcd_out;
  int          pix_period, frm_period, p, cycles, errors, check_count;
  logic [3:0]  divs [3] = '{4'h0, 4'h1, 4'hf};

  // Clock of 40 ns
  initial
  begin
    forever #20 aclk = ~aclk;
  end

  lcd_pixel_clock_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .slow_crystal_osc(slow_osc), .lcd_pixel_clock(pix), .lcd_frame(frm), .irq(irq), .lcd_out(lcd_out));

  lcd_pixel_clock_panel_model panel (.aclk(aclk), .lcd_pixel_clock(pix), .lcd_frame(frm),
    .slow_crystal_osc(slow_osc), .pix_period(pix_period), .frm_period(frm_period));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Write one register word; address and data offered together
  task automatic axi_wr(input logic [9:0] idx, input logic [7:0] d);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    check({31'h0, wready}, 32'h1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  // Read one register word into rd and resp
  task automatic axi_rd(input logic [9:0] idx);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Poll the on_32k status bit of the system register until it shows the wanted value
  task automatic poll(input logic want);
    for (int n = 0; n < 3000; n++)
    begin
      axi_rd(IDX_SYS);
      if (rd[SYS_SEL_BIT] === want)
        break;
    end
    check({31'h0, rd[SYS_SEL_BIT]}, {31'h0, want});
  endtask

  // Wait for the interrupt line; a frame on the slow clock takes about 6100 cycles
  task automatic wait_irq();
    for (int n = 0; n < 8000 && irq !== 1'b1; n++)
      @(posedge aclk);
    check({31'h0, irq}, 32'h1);
  endtask

  // Hang guard
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      errors++;
      wrap_up();
    end
  end

  // Main sequence
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(IDX_LCD_CONTROL);
    check(rd, {24'h0, RST_LCD_CONTROL});
    check({31'h0, lcd_out.display_off_bit}, 32'h1);
    axi_rd(IDX_LCD_CLOCK);
    check(rd, 32'h0);
    axi_rd(10'h3ff);
    check({30'h0, resp}, {30'h0, RESP_DECERR});
    axi_wr(10'h3ff, 8'h11);
    check({30'h0, resp}, {30'h0, RESP_DECERR});
    axi_wr(IDX_LINE_LEN, 8'h02);
    axi_wr(IDX_FRA, 8'h01);
    axi_wr(IDX_LINE_CNT, 8'h01);
    // Every mode against three dividers and three bus widths
    for (int m = 0; m < 4; m++)
    begin
      axi_wr(IDX_LCD_CONTROL, {4'h8, (m == 0) ? 2'b00 : 2'(m - 1), 2'b00});
      axi_wr(IDX_LCD_CONTROL, {4'h8, m[1:0], 2'b00});
      axi_wr(IDX_LCD_CONTROL, {4'h0, m[1:0], 2'b00});
      for (int k = 0; k < 3; k++)
      begin
        axi_wr(IDX_LCD_CLOCK, {2'b00, k[1:0], divs[k]});
        p = (divs[k] == 0 ? 1 : 2 * divs[k]) * (m == 3 ? 8 : 1);
        repeat (24 * p + 40) @(posedge aclk);
        check(pix_period, p);
        check(frm_period, 8 * p);
        check({30'h0, lcd_out.gray_level_sel}, m);
        check({30'h0, lcd_out.lcd_bus_width}, k);
      end
    end
    // Frame interrupt raised, masked and cleared
    axi_wr(IDX_IRQ_EN, 8'h80);
    wait_irq();
    check({31'h0, irq}, 32'h1);
    axi_wr(IDX_IRQ_EN, 8'h00);
    repeat (3) @(posedge aclk);
    check({31'h0, irq}, 32'h0);
    axi_wr(IDX_IRQ_EN, 8'h80);
    repeat (3) @(posedge aclk);
    check({31'h0, irq}, 32'h1);
    axi_wr(IDX_IRQ_REQ, 8'h7f);
    repeat (3) @(posedge aclk);
    check({31'h0, irq}, 32'h0);
    // Fast mode is set; switch to 32 kHz after a frame event
    wait_irq();
    axi_wr(IDX_SYS, 8'h80);
    poll(1'b1);
    check({31'h0, lcd_out.on_32k}, 32'h1);
    check({24'h0, lcd_out.pump_clock_sel}, {24'h0, PUMP_32K});
    axi_wr(IDX_LCD_CONTROL, 8'h8c);
    axi_wr(IDX_LCD_CONTROL, 8'hf0);
    axi_wr(IDX_PAN, 8'h55);
    axi_wr(IDX_LCD_CLOCK, 8'h01);
    repeat (3) @(posedge aclk);
    check({30'h0, lcd_out.gray_level_sel}, {30'h0, GL_FAST});
    check({28'h0, lcd_out.display_off_bit, lcd_out.blink_bit, lcd_out.reverse_video_bit,
           lcd_out.cascade_bit}, 32'hf);
    check({24'h0, lcd_out.panning_offset}, 32'h0);
    axi_wr(IDX_FRA, 8'h09);
    axi_rd(IDX_FRA);
    check(rd, 32'h1);
    repeat (2000) @(posedge aclk);
    check(pix_period, 763);
    axi_wr(IDX_IRQ_REQ, 8'h7f);
    axi_rd(IDX_IRQ_REQ);
    check(rd & 32'h81, 32'h01);
    // Back to RC in fast mode
    axi_wr(IDX_LCD_CONTROL, 8'h8c);
    axi_wr(IDX_LCD_CONTROL, 8'h0c);
    wait_irq();
    axi_wr(IDX_SYS, 8'h00);
    poll(1'b0);
    check({31'h0, lcd_out.on_32k}, 32'h0);
    axi_wr(IDX_PUMP, RST_PUMP);
    wrap_up();
  end
endmodule
